// *** pio_host_pkg.sv ***
// Shared constants, carriers and helpers for the programmed-I/O host controller.
`default_nettype none

package pio_host_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode encoding and widths.

    // Modes 0 to 4 are the IDE-compatible programmed-I/O modes.
    localparam int MODE_COUNT = 6;
    // Mode 5 runs a PC-card style I/O cycle.
    localparam logic [2:0] MODE_PCCARD_IO = 3'h5;
    // Width of every cycle counter.
    localparam int CYC_W = 10;
    // Nominal clock period in nanoseconds (200 MHz).
    localparam int CLK_PERIOD_NS = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-mode timing figures in nanoseconds, index = mode.

    // Minimum total strobe cycle; the PC-card cycle has no such minimum.
    localparam int T0_NS [0:5] = '{600, 383, 240, 180, 120, 0};
    // Address setup before the strobe falls.
    localparam int T1_NS [0:5] = '{70, 50, 30, 30, 25, 70};
    // Minimum strobe active width.
    localparam int T2_NS [0:5] = '{165, 125, 100, 80, 70, 165};
    // Minimum strobe recovery; none is given below mode 3.
    localparam int T2I_NS [0:5] = '{0, 0, 0, 70, 25, 0};
    // Write data hold after the strobe rises.
    localparam int T4_NS [0:5] = '{30, 20, 15, 10, 10, 30};
    // Address hold after the strobe rises.
    localparam int T9_NS [0:5] = '{20, 15, 10, 10, 10, 20};
    // Longest time the card may keep driving data after a read strobe.
    localparam int T6Z_NS = 30;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers.

    // One transfer request from the user side.
    typedef struct packed {
        logic        write;     // One for a write, zero for a read.
        logic [2:0]  mode;      // Timing mode, 0..4 IDE, 5 PC-card I/O.
        logic        cmd_sel;   // Assert the command block select.
        logic        ctl_sel;   // Assert the control block select.
        logic [2:0]  addr;      // Device register address.
        logic [15:0] wdata;     // Write data.
    } pio_req_s;

    // Result of one finished transfer.
    typedef struct packed {
        logic [15:0] rdata;     // Data sampled at the end of a read strobe.
        logic        wide;      // Card flagged a 16-bit port during the cycle.
        logic        acked;     // Card drove input acknowledge during the read.
    } pio_rsp_s;

    // Phase lengths of one cycle in clock cycles.
    typedef struct packed {
        logic [CYC_W-1:0] setup;  // Address valid to strobe fall.
        logic [CYC_W-1:0] act;    // Strobe low.
        logic [CYC_W-1:0] tail;   // Strobe high with address still held.
        logic [CYC_W-1:0] cyc;    // Minimum fall to end of cycle.
    } pio_timing_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Least time to whole clock cycles, rounded up, never below one.
    function automatic int ns_to_cyc(input int ns, input int period);
        int c;
        c = (ns + period - 1) / period;
        if (c < 1) begin
            c = 1;
        end
        return c;
    endfunction

    // Larger of two integers.
    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

endpackage

`default_nettype wire

// *** pio_timing_lookup.sv ***
// Mode to phase-length lookup for the programmed-I/O host controller.
`timescale 1ns/1ps
`default_nettype none

module pio_timing_lookup #(
    parameter int PERIOD_NS = pio_host_pkg::CLK_PERIOD_NS
) (
    // Selected mode.
    input  wire logic [2:0]                mode,
    // Phase lengths in clock cycles.
    output var  pio_host_pkg::pio_timing_s tim
);
    import pio_host_pkg::*;

    // Every count is a least time, so every conversion rounds up.
    always_comb begin
        int idx;
        int t0;
        int act;
        int tail;
        idx = (int'(mode) < MODE_COUNT) ? int'(mode) : 0;
        t0 = ns_to_cyc(T0_NS[idx], PERIOD_NS);
        act = ns_to_cyc(T2_NS[idx], PERIOD_NS);
        // The tail covers recovery, both holds and the card's bus float,
        // then stretches recovery until the whole cycle reaches its minimum.
        tail = imax(ns_to_cyc(T2I_NS[idx], PERIOD_NS), ns_to_cyc(T9_NS[idx], PERIOD_NS));
        tail = imax(tail, ns_to_cyc(T4_NS[idx], PERIOD_NS));
        tail = imax(tail, ns_to_cyc(T6Z_NS, PERIOD_NS));
        tail = imax(tail, t0 - act);
        tim.setup = CYC_W'(ns_to_cyc(T1_NS[idx], PERIOD_NS));
        tim.act = CYC_W'(act);
        tim.tail = CYC_W'(tail);
        tim.cyc = CYC_W'(t0);
    end

endmodule

`default_nettype wire

// *** pio_host_ctrl.sv ***
// Host-side controller that runs programmed-I/O cycles against a storage card.
`timescale 1ns/1ps
`default_nettype none

module pio_host_ctrl #(
    parameter int PERIOD_NS = pio_host_pkg::CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // User request port.
    input  wire logic                   req_valid,
    input  wire pio_host_pkg::pio_req_s req,
    output var  logic                   req_ready,
    // User answer port.
    output var  logic                   rsp_valid,
    output var  pio_host_pkg::pio_rsp_s rsp,
    // Card pins, active low where named so.
    output var  logic                   command_block_select_n,
    output var  logic                   control_block_select_n,
    output var  logic [2:0]             device_register_address,
    output var  logic                   io_read_strobe_n,
    output var  logic                   io_write_strobe_n,
    output var  logic [15:0]            device_data_out,
    output var  logic                   device_data_oe_n,
    input  wire logic [15:0]            device_data_in,
    input  wire logic                   input_acknowledge_n,
    input  wire logic                   wide_port_indication_n
);
    import pio_host_pkg::*;

    // Counts above the counter width cannot be served, so such a clock is refused
    // while the design is built rather than once it runs.
    if (PERIOD_NS < 1 || ns_to_cyc(T0_NS[0], PERIOD_NS) >= (1 << CYC_W)) begin : g_bad_period
        $error("pio_host_ctrl: PERIOD_NS out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State and timing.

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ACTIVE,
        ST_TAIL
    } phase_e;

    phase_e           phase;      // Current phase of the cycle.
    logic [CYC_W-1:0] cnt;        // Cycles left in the current phase.
    pio_timing_s      tim;        // Phase lengths latched for this cycle.
    pio_timing_s      next_tim;   // Phase lengths for the requested mode.
    logic             is_write;   // Latched direction of this cycle.

    pio_timing_lookup #(
        .PERIOD_NS (PERIOD_NS)
    ) u_lookup (
        .mode (req.mode),
        .tim  (next_tim)
    );

    wire logic take = req_valid && req_ready;

    // Phase sequencer: every interval is a count of own clocks, rounded up,
    // and no ready or wait input is ever sampled, since the card never stalls.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase <= ST_IDLE;
            cnt <= '0;
            tim <= '0;
            is_write <= 1'b0;
        end else begin
            case (phase)
                ST_IDLE: begin
                    // Address and selects go out now; strobe waits for setup.
                    if (take) begin
                        tim <= next_tim;
                        is_write <= req.write;
                        cnt <= next_tim.setup - CYC_W'(1);
                        phase <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt == '0) begin
                        cnt <= tim.act - CYC_W'(1);
                        phase <= ST_ACTIVE;
                    end else begin
                        cnt <= cnt - CYC_W'(1);
                    end
                end
                ST_ACTIVE: begin
                    if (cnt == '0) begin
                        // Tail holds address and data and lets the card float.
                        cnt <= tim.tail - CYC_W'(1);
                        phase <= ST_TAIL;
                    end else begin
                        cnt <= cnt - CYC_W'(1);
                    end
                end
                ST_TAIL: begin
                    if (cnt == '0) begin
                        phase <= ST_IDLE;
                    end else begin
                        cnt <= cnt - CYC_W'(1);
                    end
                end
                default: begin
                    phase <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    // Address changes only when a cycle is taken and selects also rise at the end
    // of the tail, so both stay stable through setup, active and tail alike.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            command_block_select_n <= 1'b1;
            control_block_select_n <= 1'b1;
            device_register_address <= 3'h0;
        end else if (take) begin
            command_block_select_n <= !req.cmd_sel;
            control_block_select_n <= !req.ctl_sel;
            device_register_address <= req.addr;
        end else if (phase == ST_TAIL && cnt == '0) begin
            command_block_select_n <= 1'b1;
            control_block_select_n <= 1'b1;
        end
    end

    // Strobes: low exactly for the active phase, never both at once.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
        end else if (phase == ST_SETUP && cnt == '0) begin
            io_read_strobe_n <= is_write;
            io_write_strobe_n <= !is_write;
        end else if (phase == ST_ACTIVE && cnt == '0) begin
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
        end
    end

    // Write data is driven from the start of setup to the end of the tail,
    // which covers data setup and hold; reads never drive the bus.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            device_data_out <= 16'h0000;
            device_data_oe_n <= 1'b1;
        end else if (take) begin
            device_data_out <= req.wdata;
            device_data_oe_n <= !req.write;
        end else if (phase == ST_TAIL && cnt == '0) begin
            device_data_oe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // User handshake and answer.

    // Read data and card flags are sampled in the last active cycle, when the
    // card's data has been valid for two cycles or more; the pins count as synchronous inputs.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsp <= '0;
        end else if (phase == ST_ACTIVE && cnt == '0) begin
            rsp.rdata <= is_write ? 16'h0000 : device_data_in;
            rsp.wide <= !wide_port_indication_n;
            rsp.acked <= !is_write && !input_acknowledge_n;
        end
    end

    // Ready drops on the take and returns with the answer pulse.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (phase == ST_TAIL && cnt == '0);
            if (take) begin
                req_ready <= 1'b0;
            end else if (phase == ST_TAIL && cnt == '0) begin
                req_ready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checking helpers and assertions.

    wire logic strobe_low = !io_read_strobe_n || !io_write_strobe_n;
    logic [CYC_W-1:0] low_cnt;     // Cycles the strobe has been low.
    logic [CYC_W-1:0] high_cnt;    // Cycles the strobe has been high.
    logic [CYC_W-1:0] fall_cnt;    // Cycles since the last strobe fall.
    logic [CYC_W-1:0] addr_cnt;    // Cycles the address has been stable.
    logic             strobe_q;    // Strobe low one cycle ago.
    logic [CYC_W-1:0] rec_min;     // Tail length of the cycle whose strobe last rose.

    // Counters watched only by the assertions; all but low_cnt saturate.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= '0;
            high_cnt <= '1;
            fall_cnt <= '1;
            addr_cnt <= '1;
            strobe_q <= 1'b0;
            rec_min <= '0;
        end else begin
            strobe_q <= strobe_low;
            // Recovery belongs to the cycle that just ended, not to the next one.
            if (phase == ST_ACTIVE && cnt == '0) begin
                rec_min <= tim.tail;
            end
            low_cnt <= strobe_low ? low_cnt + CYC_W'(1) : '0;
            high_cnt <= strobe_low ? '0 : ((high_cnt == '1) ? high_cnt : high_cnt + CYC_W'(1));
            fall_cnt <= (strobe_low && !strobe_q) ? CYC_W'(1) :
                        ((fall_cnt == '1) ? fall_cnt : fall_cnt + CYC_W'(1));
            addr_cnt <= take ? '0 : ((addr_cnt == '1) ? addr_cnt : addr_cnt + CYC_W'(1));
        end
    end

    AST_NO_CONTENTION: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !io_read_strobe_n |-> device_data_oe_n)
        else $error("host drives data during a read strobe");
    AST_ONE_STROBE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(!io_read_strobe_n && !io_write_strobe_n))
        else $error("both strobes low");
    AST_ACTIVE_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!strobe_low && strobe_q) |-> ($past(low_cnt) + CYC_W'(1) >= tim.act))
        else $error("strobe active too short");
    AST_RECOVERY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (strobe_low && !strobe_q) |-> (high_cnt >= rec_min))
        else $error("strobe recovery too short");
    AST_ADDR_SETUP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (strobe_low && !strobe_q) |-> (addr_cnt >= tim.setup))
        else $error("address setup too short");
    AST_CYCLE_TIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rsp_valid) |-> (fall_cnt >= tim.cyc))
        else $error("total cycle too short");
    AST_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!strobe_low && strobe_q) |-> $stable(device_register_address)
            ##1 $stable(device_register_address))
        else $error("address changed during hold");
    AST_DATA_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(io_write_strobe_n) |-> !device_data_oe_n && $stable(device_data_out))
        else $error("write data released at strobe rise");
    AST_RSP_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rsp_valid |-> req_ready ##1 !rsp_valid)
        else $error("answer longer than one cycle");

    COV_READ: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(io_read_strobe_n) ##[1:200] rsp_valid);
    COV_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(io_write_strobe_n) ##[1:200] rsp_valid);
    COV_PCCARD: cover property (@(posedge clk_sys) disable iff (!rst_n)
        take && req.mode == MODE_PCCARD_IO);
    COV_BACK_TO_BACK: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rsp_valid && take);

endmodule

`default_nettype wire

// *** pio_card_model.sv ***
// Behavioural storage card answering the host controller's cycles.
`timescale 1ns/1ps
`default_nettype none

module pio_card_model (
    // Clock, reset and pacing.
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        slow,
    // Card pins.
    input  wire logic        command_block_select_n,
    input  wire logic        control_block_select_n,
    input  wire logic [2:0]  device_register_address,
    input  wire logic        io_read_strobe_n,
    input  wire logic        io_write_strobe_n,
    input  wire logic [15:0] device_data_out,
    input  wire logic        device_data_oe_n,
    output logic      [15:0] device_data_in,
    output logic             input_acknowledge_n,
    output logic             wide_port_indication_n,
    // Sticky flag for host contention or a floated write.
    output logic             fault
);
    ////////////////////////////////////////////////////////////////////////////////
    // Minimum cycle time this card would report, 120 ns.
    localparam logic [15:0] CYCLE_WORD = 16'h0078;
    logic [15:0] mem [0:15]; // Register image, control block in the upper half.
    logic [15:0] last;       // Last value the card drove.
    logic [4:0]  cnt;        // Cycles the read strobe has been low.
    logic        wr_q;       // Write strobe one cycle ago.
    logic        drive;      // Card drives the data lines.
    logic [3:0]  idx;        // Selected register.

    assign idx = {~control_block_select_n, device_register_address};
    // A slow card still answers inside the shortest strobe, two cycles before it ends.
    assign drive = !io_read_strobe_n && (cnt >= (slow ? 5'd12 : 5'd2));
    // Released lines show the inverse, so a stale copy is never mistaken for data.
    assign device_data_in = drive ? mem[idx] : ~last;
    // No wait or ready pin exists; only acknowledge follows the strobe.
    assign input_acknowledge_n = io_read_strobe_n || (cnt == 5'd0);
    assign wide_port_indication_n = command_block_select_n || (device_register_address != 3'h0);

    ////////////////////////////////////////////////////////////////////////////////
    // Count strobe time, store writes one cycle after the strobe's rise, watch the bus.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            wr_q <= 1'b1;
            last <= 16'h0000;
            fault <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 16'h0000;
            end
        end else begin
            cnt <= io_read_strobe_n ? 5'h00 : ((cnt == 5'h1f) ? cnt : cnt + 5'h01);
            wr_q <= io_write_strobe_n;
            if (drive) begin
                last <= mem[idx];
            end
            if (!wr_q && io_write_strobe_n) begin
                mem[idx] <= device_data_out;
            end
            if ((drive && !device_data_oe_n) || (!io_write_strobe_n && device_data_oe_n)) begin
                fault <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb_pio_host_ctrl.sv ***
// Self-checking bench for the programmed-I/O host controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_pio_host_ctrl;
    import pio_host_pkg::*;
    // One case: mode, block, register and data, written then read back.
    typedef struct packed {
        logic [2:0]  mode;
        logic        ctl;
        logic [2:0]  addr;
        logic [15:0] data;
    } row_s;
    // A taken request and what the card should return.
    typedef struct packed {
        pio_req_s    r;
        logic [15:0] exp;
    } pend_s;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    logic        slow = 1'b0;
    pio_req_s    req = '0;
    logic        req_ready, rsp_valid, cbs_n, kbs_n, rd_n, wr_n, oe_n, ack_n, wide_n, fault;
    pio_rsp_s    rsp;
    logic [2:0]  dra;
    logic [15:0] dout, din;
    logic [15:0] shadow [0:15];          // Expected register image.
    pend_s       q[$];                   // Transfers in flight.
    pend_s       cur;
    int          err_total, num_checks, cyc, t_take, t_fall, last_rise, last_fall, last_m, m;
    logic        prev_strb, strb;
    row_s        rows [8] = '{'{3'h0, 1'b0, 3'h0, 16'ha5c3}, '{3'h1, 1'b0, 3'h1, 16'h5a3c},
        '{3'h2, 1'b1, 3'h6, 16'hffff}, '{3'h3, 1'b0, 3'h0, 16'h0001},
        '{3'h4, 1'b0, 3'h7, 16'h8000}, '{3'h4, 1'b1, 3'h0, 16'h1357},
        '{3'h5, 1'b0, 3'h0, 16'hbeef}, '{3'h7, 1'b1, 3'h2, 16'h0f0f}};

    always #2.5 clk_sys = ~clk_sys;

    pio_host_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .command_block_select_n(cbs_n), .control_block_select_n(kbs_n),
        .device_register_address(dra), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
        .device_data_out(dout), .device_data_oe_n(oe_n), .device_data_in(din),
        .input_acknowledge_n(ack_n), .wide_port_indication_n(wide_n));
    pio_card_model i_card (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
        .command_block_select_n(cbs_n), .control_block_select_n(kbs_n),
        .device_register_address(dra), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
        .device_data_out(dout), .device_data_oe_n(oe_n), .device_data_in(din),
        .input_acknowledge_n(ack_n), .wide_port_indication_n(wide_n), .fault(fault));

    ////////////////////////////////////////////////////////////////////////////////
    // Nanoseconds to whole clocks, rounded up.
    function automatic int cy(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction
    // Strobe-high clocks after a strobe: every hold and the cycle minimum.
    function automatic int tail(input int k);
        int t;
        t = cy(T0_NS[k]) - cy(T2_NS[k]);
        t = (cy(T2I_NS[k]) > t) ? cy(T2I_NS[k]) : t;
        t = (cy(T9_NS[k]) > t) ? cy(T9_NS[k]) : t;
        t = (cy(T4_NS[k]) > t) ? cy(T4_NS[k]) : t;
        t = (cy(T6Z_NS) > t) ? cy(T6Z_NS) : t;
        return (t < 1) ? 1 : t;
    endfunction
    function automatic pio_req_s mk(input logic w, input row_s r);
        return '{w, r.mode, !r.ctl, r.ctl, r.addr, r.data};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin monitor: phase lengths, pin values and answers of each transfer.
    always @(posedge clk_sys) begin
        strb = rd_n & wr_n;
        if (!rst_n) begin
            q.delete();
            foreach (shadow[i]) shadow[i] = 16'h0000;
            last_rise = -1000;
            last_fall = -1000;
            last_m = 0;
        end else if (q.size() > 0) begin
            cur = q[0];
            m = (cur.r.mode > 3'h5) ? 0 : int'(cur.r.mode);
            if (prev_strb && !strb) begin
                `CHK(cyc - t_take, cy(T1_NS[m]) + 1)
                `CHK({cbs_n, kbs_n, dra}, {!cur.r.cmd_sel, !cur.r.ctl_sel, cur.r.addr})
                `CHK({rd_n, wr_n}, {cur.r.write, !cur.r.write})
                if (cur.r.write) `CHK(dout, cur.r.wdata)
                `CHK(cyc - last_rise >= cy(T2I_NS[last_m]), 1'b1)
                `CHK(cyc - last_fall >= cy(T0_NS[last_m]), 1'b1)
                t_fall = cyc;
                last_fall = cyc;
                last_m = m;
            end
            if (!prev_strb && strb) begin
                `CHK(cyc - t_fall, cy(T2_NS[m]))
                last_rise = cyc;
            end
            if (cyc > t_take && !rsp_valid) `CHK(oe_n, !cur.r.write)
            if (rsp_valid) begin
                `CHK(cyc - last_rise, tail(m))
                `CHK(rsp.wide, cur.r.cmd_sel && cur.r.addr == 3'h0)
                if (!cur.r.write) `CHK({rsp.rdata, rsp.acked}, {cur.exp, 1'b1})
                if (cur.r.write) `CHK({rsp.rdata, rsp.acked}, 17'h0)
                void'(q.pop_front());
            end
        end
        if (rst_n && req_valid && req_ready) begin
            t_take = cyc;
            q.push_back('{req, shadow[{req.ctl_sel, req.addr}]});
            if (req.write) shadow[{req.ctl_sel, req.addr}] = req.wdata;
        end
        prev_strb = strb;
        cyc++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Present one request and return at the edge that takes it.
    task automatic send(input pio_req_s r);
        int n;
        n = 0;
        req <= r;
        req_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        if (n >= 400) err_total++;
    endtask
    // Drop the request and wait until the controller is idle.
    task automatic settle();
        int n;
        n = 0;
        req_valid <= 1'b0;
        @(posedge clk_sys);
        while ((req_ready !== 1'b1 || q.size() != 0) && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 400) err_total++;
    endtask
    task automatic idle_chk();
        `CHK({req_ready, rsp_valid, cbs_n, kbs_n, rd_n, wr_n, oe_n}, 7'h5f)
        `CHK({dra, dout, rsp}, 37'h0)
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well beyond the whole sequence.
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        idle_chk();
        rst_n <= 1'b1;
        @(posedge clk_sys);
        idle_chk();
        // Every mode, write then read back to back.
        foreach (rows[i]) begin
            send(mk(1'b1, rows[i]));
            send(mk(1'b0, rows[i]));
        end
        settle();
        // Slow card, back-to-back reads in the fastest mode.
        slow <= 1'b1;
        send(mk(1'b0, rows[4]));
        send(mk(1'b0, rows[5]));
        settle();
        slow <= 1'b0;
        // Untouched register reads back as zero.
        send(mk(1'b0, '{3'h2, 1'b1, 3'h7, 16'h0}));
        settle();
        // Reset while a strobe is low, then recover.
        send(mk(1'b1, rows[0]));
        req_valid <= 1'b0;
        repeat (40) @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        idle_chk();
        rst_n <= 1'b1;
        @(posedge clk_sys);
        send(mk(1'b1, rows[3]));
        send(mk(1'b0, rows[3]));
        settle();
        `CHK(fault, 1'b0)
        end_of_test();
    end
endmodule

`default_nettype wire
